// >>> core/tmon_defines.vh
// constants for the two-channel temperature monitor core
// assumes a 40 MHz core clock and an 8-bit axi4-lite byte address
`ifndef TMON_DEFINES_VH
`define TMON_DEFINES_VH
// clock and times
`define TM_CLK_MHZ   40
`define TM_TOUT_MS   25
`define TM_CONV_US   15500
`define TM_AVG_N     4'hf
// register byte offsets
`define TM_OFF_LVAL  8'h00
`define TM_OFF_RHI   8'h04
`define TM_OFF_RLO   8'h08
`define TM_OFF_STAT  8'h0c
`define TM_OFF_CFG   8'h10
`define TM_OFF_RATE  8'h14
`define TM_OFF_ARA   8'h18
`define TM_OFF_TOUT  8'h1c
`define TM_OFF_LIM0  8'h20
`define TM_LIM_LAST  4'h8
// limit indices
`define TM_L_LHI     4'h0
`define TM_L_LLO     4'h1
`define TM_L_LTH     4'h2
`define TM_L_RHIH    4'h3
`define TM_L_RHIL    4'h4
`define TM_L_RLOH    4'h5
`define TM_L_RLOL    4'h6
`define TM_L_RTH     4'h7
`define TM_L_HYST    4'h8
// reset values
`define TM_RST_HI    8'h55
`define TM_RST_LO    8'h00
`define TM_RST_HYST  8'h0a
`define TM_RST_RATE  4'h8
`define TM_RATE_MAX  4'ha
// field positions
`define TM_CFG_MASK  7
`define TM_CFG_STBY  6
// bus answers
`define TM_RESP_OK   2'h0
`define TM_RESP_ERR  2'h2
`endif

// >>> core/tmon_core.v
// two-channel temperature monitor core: converter sequencing, averaging,
// limit compare, status flags, alert and overtemp outputs, axi4-lite regs
// assumes an adc front end on i_clk and a serial clock pin from outside
`timescale 1ns/10ps
`include "tmon_defines.vh"

// Behaviour
// R1: converter runs freely without host commands
// R2: conversions alternate local and remote channel
// R3: results go to their channel value register
// R4: results compared against nine limit registers
// R5: failed comparison sets its status flag
// R6: any out-of-limit drives alert output low
// R7: overtemp limit exceeded drives comparator low
// R8: host writes limits and all settings
// R9: host reads back every register
// R10: standby, alert mask and rate controls
// R11: reported value averages sixteen measurements
// R12: one lsb equals one eighth degree
// R13: values are two's complement numbers
// R14: local and remote high byte whole degrees
// R15: optional bus timeout, off after reset
// R16: status bit layout busy down to local overtemp
// R17: status read clears only vanished conditions
// R18: alert latch cleared by alert address read
// R19: config bit7 masks alert, bit6 standby
// R20: compare only fully averaged results
module tmon_core #(
   parameter CONV_CYC = `TM_CONV_US * `TM_CLK_MHZ,        // fastest rate period
   parameter TOUT_CYC = `TM_TOUT_MS * 1000 * `TM_CLK_MHZ  // bus timeout
) (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_rst_n,
   // axi4-lite write
   input  wire [7:0]  i_awaddr,
   input  wire        i_awvalid,
   output reg         o_awready,
   input  wire [31:0] i_wdata,
   input  wire [3:0]  i_wstrb,
   input  wire        i_wvalid,
   output reg         o_wready,
   output reg  [1:0]  o_bresp,
   output reg         o_bvalid,
   input  wire        i_bready,
   // axi4-lite read
   input  wire [7:0]  i_araddr,
   input  wire        i_arvalid,
   output reg         o_arready,
   output reg  [31:0] o_rdata,
   output reg  [1:0]  o_rresp,
   output reg         o_rvalid,
   input  wire        i_rready,
   // converter front end
   output reg         o_adc_start,
   output reg         o_adc_remote,
   input  wire        i_adc_done,
   input  wire [10:0] i_adc_code,
   input  wire        i_remote_open,
   // serial bus clock pin and timeout release
   input  wire        i_serial_clk_pin,
   output reg         o_bus_release,
   // open-drain alarm outputs
   output reg         o_alert_n,
   output reg         o_overtemp_comparator_n
);
   localparam S_WAIT  = 3'h0;   // rate timer running
   localparam S_START = 3'h1;   // kick one measurement
   localparam S_CONV  = 3'h2;   // wait for measurement
   localparam S_STORE = 3'h3;   // write value register
   localparam S_CMP   = 3'h4;   // limit compare

   // register hit decode, shared by read and write paths
   function hit;
      input [7:0] a;
      input [7:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // limit index decode, shared by read and write paths
   function [4:0] lim_idx;
      input [7:0] a;
      reg   [7:0] d;
      begin
         d       = a - `TM_OFF_LIM0;
         lim_idx = {(a >= `TM_OFF_LIM0) && (d[7:2] <= {2'h0, `TM_LIM_LAST})
                    && (d[1:0] == 2'h0), d[5:2]};
      end
   endfunction

   reg  [2:0]  state;          // sequencer state
   reg         chan_remote;    // channel being measured
   reg  [31:0] timer;          // rate countdown
   reg  [3:0]  avg_cnt;        // samples taken
   reg  [14:0] acc;            // signed sum of samples
   reg  [7:0]  lval;           // local whole degrees
   reg  [7:0]  rhi;            // remote whole degrees
   reg  [7:0]  rlo;            // remote fraction, bits 7:5
   reg  [7:0]  lim [0:8];      // limit registers
   reg         cfg_mask;       // alert masked
   reg         cfg_stby;       // standby
   reg  [3:0]  rate;           // conversion rate code
   reg         tout_en;        // bus timeout enable
   reg  [4:0]  cond;           // live trip conditions, bits 6:2
   reg  [4:0]  flags;          // sticky status flags, bits 6:2
   reg         th_r;           // remote overtemp state
   reg         th_l;           // local overtemp state
   reg         alert_latch;    // alert interrupt latch
   reg  [1:0]  scl_sync;       // pin synchroniser
   reg  [31:0] tout_cnt;       // serial clock low time
   reg  [31:0] rdat;           // read mux
   reg         rd_ok;          // read address mapped
   reg  [4:0]  wl;             // write limit decode
   reg  [4:0]  rl;             // read limit decode
   reg  [7:0]  aw_q;           // held write address
   reg  [31:0] w_q;            // held write data
   reg  [3:0]  ws_q;           // held write strobes
   wire        wr_go;          // write happens this edge
   wire        rd_go;          // read taken this edge
   wire [14:0] avg_full;       // rounded-down average
   wire [10:0] avg;            // averaged code, eighths
   wire [10:0] rval;           // remote value, eighths
   wire [3:0]  rate_cl;        // rate clamped to fastest
   integer     k;

   assign wr_go    = ~o_awready & ~o_wready & ~o_bvalid;
   assign rd_go    = i_arvalid & o_arready;
   assign avg_full = $signed(acc) >>> 4;                         // [R11]
   assign avg      = avg_full[10:0];
   assign rval     = {rhi, rlo[7:5]};
   assign rate_cl  = (rate > `TM_RATE_MAX) ? `TM_RATE_MAX : rate;

   // read data mux
   always @* begin
      rl    = lim_idx(i_araddr);
      rd_ok = 1'b1;
      rdat  = 32'h0;
      if (hit(i_araddr, `TM_OFF_LVAL))
         rdat[7:0] = lval;                                       // [R9]
      else if (hit(i_araddr, `TM_OFF_RHI))
         rdat[7:0] = rhi;
      else if (hit(i_araddr, `TM_OFF_RLO))
         rdat[7:0] = rlo;
      else if (hit(i_araddr, `TM_OFF_STAT))
         rdat[7:0] = {state != S_WAIT, flags, th_r, th_l};       // [R16]
      else if (hit(i_araddr, `TM_OFF_CFG))
         rdat[7:0] = {cfg_mask, cfg_stby, 6'h00};
      else if (hit(i_araddr, `TM_OFF_RATE))
         rdat[3:0] = rate;
      else if (hit(i_araddr, `TM_OFF_ARA))
         rdat[0] = alert_latch;
      else if (hit(i_araddr, `TM_OFF_TOUT))
         rdat[0] = tout_en;
      else if (rl[4])
         rdat[7:0] = lim[rl[3:0]];
      else
         rd_ok = 1'b0;
   end

   // axi write channel: both address and data, then response
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_awready <= 1'b1;
         o_wready  <= 1'b1;
         o_bvalid  <= 1'b0;
         o_bresp   <= `TM_RESP_OK;
      end else begin
         if (i_awvalid & o_awready)
            o_awready <= 1'b0;
         if (i_wvalid & o_wready)
            o_wready <= 1'b0;
         if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp  <= (wl[4] || hit(aw_q, `TM_OFF_CFG) || hit(aw_q, `TM_OFF_RATE)
                         || hit(aw_q, `TM_OFF_TOUT)) ? `TM_RESP_OK : `TM_RESP_ERR;
         end
         if (o_bvalid & i_bready) begin
            o_bvalid  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
         end
      end
   end

   // capture write payloads
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_q <= 8'h00;
         w_q  <= 32'h0;
         ws_q <= 4'h0;
      end else begin
         if (i_awvalid & o_awready)
            aw_q <= i_awaddr;
         if (i_wvalid & o_wready) begin
            w_q  <= i_wdata;
            ws_q <= i_wstrb;
         end
      end
   end

   always @* wl = lim_idx(aw_q);

   // host settings and limits; only byte lane 0 carries data
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_mask <= 1'b0;                                       // [R19]
         cfg_stby <= 1'b0;
         rate     <= `TM_RST_RATE;
         tout_en  <= 1'b0;                                       // [R15]
         for (k = 0; k < 9; k = k + 1)
            lim[k] <= `TM_RST_HI;
         lim[`TM_L_LLO]  <= `TM_RST_LO;
         lim[`TM_L_RLOH] <= `TM_RST_LO;
         lim[`TM_L_RLOL] <= `TM_RST_LO;
         lim[`TM_L_RHIL] <= `TM_RST_LO;
         lim[`TM_L_HYST] <= `TM_RST_HYST;
      end else if (wr_go && ws_q[0]) begin                      // [R8]
         if (hit(aw_q, `TM_OFF_CFG)) begin                      // [R10]
            cfg_mask <= w_q[`TM_CFG_MASK];
            cfg_stby <= w_q[`TM_CFG_STBY];
         end else if (hit(aw_q, `TM_OFF_RATE))
            rate <= w_q[3:0];
         else if (hit(aw_q, `TM_OFF_TOUT))
            tout_en <= w_q[0];
         else if (wl[4])
            lim[wl[3:0]] <= w_q[7:0];                            // [R4]
      end
   end

   // axi read channel; the answer follows the address by one edge
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h0;
         o_rresp   <= `TM_RESP_OK;
      end else if (rd_go) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rdata   <= rdat;                                      // [R9]
         o_rresp   <= rd_ok ? `TM_RESP_OK : `TM_RESP_ERR;
      end else if (o_rvalid & i_rready) begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end

   // free-running conversion sequencer with sixteen-sample averaging
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state        <= S_WAIT;
         chan_remote  <= 1'b0;
         timer        <= 32'h0;
         avg_cnt      <= 4'h0;
         acc          <= 15'h0;
         lval         <= 8'h00;
         rhi          <= 8'h00;
         rlo          <= 8'h00;
         o_adc_start  <= 1'b0;
         o_adc_remote <= 1'b0;
         cond         <= 5'h00;
         th_r         <= 1'b0;
         th_l         <= 1'b0;
      end else begin
         o_adc_start <= 1'b0;
         case (state)
            S_WAIT: begin
               // standby holds off conversions; bus stays live
               if (timer != 32'h0)
                  timer <= timer - 32'h1;
               else if (!cfg_stby) begin                         // [R1] [R19]
                  state        <= S_START;
                  o_adc_remote <= chan_remote;
               end
            end
            S_START: begin
               o_adc_start <= 1'b1;
               state       <= S_CONV;
            end
            S_CONV: begin
               if (i_adc_done) begin
                  // sign-extend: codes are two's complement eighths
                  acc     <= acc + {{4{i_adc_code[10]}}, i_adc_code}; // [R13] [R12]
                  avg_cnt <= avg_cnt + 4'h1;
                  state   <= (avg_cnt == `TM_AVG_N) ? S_STORE : S_START; // [R11]
               end
            end
            S_STORE: begin
               acc     <= 15'h0;
               avg_cnt <= 4'h0;
               if (chan_remote) begin                           // [R3]
                  rhi <= avg[10:3];                              // [R14]
                  rlo <= {avg[2:0], 5'h00};
               end else
                  lval <= avg[10:3];                             // [R14]
               state <= S_CMP;
            end
            S_CMP: begin
               // compares see only finished, stored values
               if (chan_remote) begin                            // [R20] [R4]
                  cond[2] <= $signed(rval) > $signed({lim[`TM_L_RHIH], lim[`TM_L_RHIL][7:5]});
                  cond[1] <= $signed(rval) <= $signed({lim[`TM_L_RLOH], lim[`TM_L_RLOL][7:5]});
                  cond[0] <= i_remote_open;
                  if ($signed(rhi) > $signed(lim[`TM_L_RTH]))
                     th_r <= 1'b1;
                  else if ($signed(rhi) <= $signed(lim[`TM_L_RTH] - lim[`TM_L_HYST]))
                     th_r <= 1'b0;
               end else begin
                  cond[4] <= $signed(lval) > $signed(lim[`TM_L_LHI]);
                  cond[3] <= $signed(lval) <= $signed(lim[`TM_L_LLO]);
                  if ($signed(lval) > $signed(lim[`TM_L_LTH]))
                     th_l <= 1'b1;
                  else if ($signed(lval) <= $signed(lim[`TM_L_LTH] - lim[`TM_L_HYST]))
                     th_l <= 1'b0;
               end
               chan_remote <= ~chan_remote;                      // [R2]
               timer       <= CONV_CYC << (`TM_RATE_MAX - rate_cl); // [R10]
               state       <= S_WAIT;
            end
            default: state <= S_WAIT;
         endcase
      end
   end

   // sticky flags: a status read drops only vanished conditions, set wins
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         flags <= 5'h00;
      else if (rd_go && hit(i_araddr, `TM_OFF_STAT))
         flags <= (flags & cond) | cond;                         // [R17]
      else
         flags <= flags | cond;                                  // [R5]
   end

   // alert latch: status reads leave it, alert address read may clear it
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         alert_latch <= 1'b0;
      else if (|flags || |cond)
         alert_latch <= 1'b1;                                    // [R6]
      else if (rd_go && hit(i_araddr, `TM_OFF_ARA))
         alert_latch <= 1'b0;                                    // [R18]
   end

   // open-drain alarm pins, registered
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_alert_n               <= 1'b1;
         o_overtemp_comparator_n <= 1'b1;
      end else begin
         o_alert_n               <= ~(alert_latch & ~cfg_mask);  // [R6] [R19]
         o_overtemp_comparator_n <= ~(th_r | th_l);              // [R7]
      end
   end

   // serial clock pin: two-flop synchroniser, then stuck-low timeout
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_sync      <= 2'h3;
         tout_cnt      <= 32'h0;
         o_bus_release <= 1'b0;
      end else begin
         scl_sync <= {scl_sync[0], i_serial_clk_pin};
         // a high clock ends the hold-off, so a release lasts until then
         if (!tout_en || scl_sync[1]) begin
            tout_cnt      <= 32'h0;
            o_bus_release <= 1'b0;
         end else if (tout_cnt >= TOUT_CYC - 1)
            o_bus_release <= 1'b1;                               // [R15]
         else
            tout_cnt <= tout_cnt + 32'h1;
      end
   end

endmodule // tmon_core

// >>> verif/tmon_adc_model.sv
// behavioural converter front end for the monitor core
// assumes start pulses on the core clock; answers after i_delay cycles
`timescale 1ns/10ps
module tmon_adc_model (
   // clock
   input  wire        i_clk,
   // requests from the core
   input  wire        i_start,
   input  wire        i_remote,
   // codes per channel and answer delay
   input  wire [10:0] i_lcode,
   input  wire [10:0] i_rcode,
   input  wire [3:0]  i_delay,
   // answer
   output reg         o_done,
   output reg  [10:0] o_code
);
   integer cnt = 0;                 // cycles left until done
   initial o_code = 11'h000;
   // code is only valid with done; otherwise it wanders
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      o_code <= ~o_code;
      if (i_start) begin
         cnt <= i_delay;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt == 1) begin
            o_done <= 1'b1;
            o_code <= i_remote ? i_rcode : i_lcode;
         end
      end
   end
endmodule // tmon_adc_model

// >>> verif/tmon_core_sva.sv
// port-level checker for the monitor core
// assumes one clock domain and the low-active asynchronous reset
`timescale 1ns/10ps
module tmon_core_sva #(
   parameter TOUT_CYC = 50
) (
   input wire        i_clk,
   input wire        i_rst_n,
   input wire        i_awvalid,
   input wire        o_awready,
   input wire        i_wvalid,
   input wire        o_wready,
   input wire [1:0]  o_bresp,
   input wire        o_bvalid,
   input wire        i_bready,
   input wire        i_arvalid,
   input wire        o_arready,
   input wire [31:0] o_rdata,
   input wire        o_rvalid,
   input wire        i_rready,
   input wire        o_adc_start,
   input wire        o_adc_remote,
   input wire        i_serial_clk_pin,
   input wire        o_bus_release
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   integer low_cnt;                 // clock pin low time, raw pin
   // sync delay only makes this count larger than the core's
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) low_cnt <= 0;
      else low_cnt <= i_serial_clk_pin ? 0 : low_cnt + 1;
   end
   sequence s_wr_take;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   sequence s_rd_take;
      i_arvalid && o_arready;
   endsequence
   a_start_pulse: assert property (
      o_adc_start |=> !o_adc_start) else $error("start pulse too long");
   a_chan_hold: assert property (
      o_adc_start |-> $stable(o_adc_remote)) else $error("channel moved at start");
   a_write_resp: assert property (
      s_wr_take |=> ##1 o_bvalid) else $error("no write response");
   a_bresp_hold: assert property (
      o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp)) else $error("bresp dropped");
   a_aw_blocked: assert property (
      o_bvalid |-> !o_awready && !o_wready) else $error("write taken early");
   a_read_resp: assert property (
      s_rd_take |=> o_rvalid && !o_arready) else $error("no read response");
   a_rdata_hold: assert property (
      o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)) else $error("rdata dropped");
   a_release_cause: assert property (
      $rose(o_bus_release) |-> low_cnt >= TOUT_CYC) else $error("release too early");
   a_release_clear: assert property (
      i_serial_clk_pin [*4] |=> !o_bus_release) else $error("release stuck");
endmodule // tmon_core_sva
bind tmon_core tmon_core_sva #(.TOUT_CYC(TOUT_CYC)) u_sva (.i_clk, .i_rst_n, .i_awvalid,
   .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid,
   .o_arready, .o_rdata, .o_rvalid, .i_rready, .o_adc_start, .o_adc_remote,
   .i_serial_clk_pin, .o_bus_release);

// >>> verif/tmon_core_test.sv
// self-checking bench for the monitor core over axi4-lite
// assumes short conversion and timeout counts set by parameters
`timescale 1ns/10ps
`define CHK(a,e) begin total_checks++; if ((a)!==(e)) begin n_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tmon_core_test;
   reg clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   reg sclk = 1, open = 0;          // link clock idles high
   reg [7:0] awa = 0, ara = 0;
   reg [31:0] wd = 0;
   reg [3:0] dly = 3;               // converter answer delay
   wire awr, wrdy, bv, arr, rv, st, rem, done, rel, al_n, ot_n;
   wire [1:0] br, rr;
   wire [31:0] rdat;
   wire [10:0] code;
   integer n_errors = 0, total_checks = 0, starts = 0, i;
   localparam [71:0] LR = 72'h55_00_55_55_00_00_00_55_0a; // limit resets
   initial forever #12.5 clk = ~clk;
   tmon_core #(.CONV_CYC(20), .TOUT_CYC(50)) dut (.i_clk(clk), .i_rst_n(rst_n),
      .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'h1),
      .i_wvalid(wv), .o_wready(wrdy), .o_bresp(br), .o_bvalid(bv), .i_bready(bry),
      .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdat), .o_rresp(rr),
      .o_rvalid(rv), .i_rready(rry), .o_adc_start(st), .o_adc_remote(rem),
      .i_adc_done(done), .i_adc_code(code), .i_remote_open(open),
      .i_serial_clk_pin(sclk), .o_bus_release(rel), .o_alert_n(al_n),
      .o_overtemp_comparator_n(ot_n));
   // local 25.0 degrees, remote 100.5 degrees
   tmon_adc_model adc (.i_clk(clk), .i_start(st), .i_remote(rem), .i_lcode(11'h0c8),
      .i_rcode(11'h324), .i_delay(dly), .o_done(done), .o_code(code));
   always @(posedge clk) if (st) starts <= starts + 1;
   task end_of_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task tmo;
      n_errors++;
      $display("[ERR] %0t wait ran out", $time);
      end_of_test;
   endtask
   task wt(input integer n);
      repeat (n) @(posedge clk);
   endtask
   // one write; address and data released as each is taken
   task wr(input [7:0] a, input [7:0] v, input [1:0] e);
      integer k;
      awa <= a; wd <= {24'h0, v}; awv <= 1; wv <= 1; bry <= 1;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wrdy) wv <= 0;
         if (bv) break;
      end
      if (k == 50) tmo;
      `CHK(br, e)
      bry <= 0;
      @(posedge clk);
   endtask
   // one read, masked compare of data and response
   task rd(input [7:0] a, input [31:0] e, input [31:0] m, input [1:0] er);
      integer k;
      ara <= a; arv <= 1; rry <= 1;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (arr) arv <= 0;
         if (rv) break;
      end
      if (k == 50) tmo;
      `CHK(rdat & m, e)
      `CHK(rr, er)
      rry <= 0;
      @(posedge clk);
   endtask
   // link clock frame, 200 ns period, stops where it started
   task link(input integer n);
      repeat (n) begin
         sclk <= ~sclk;
         wt(4);
      end
   endtask
   initial begin
      wt(50000);
      tmo;
   end
   initial begin
      wt(16);
      rst_n <= 1;
      @(posedge clk);
      rd(8'h10, 0, 32'hffffffff, 0);
      rd(8'h14, 8, 32'hffffffff, 0);
      rd(8'h1c, 0, 32'hffffffff, 0);
      for (i = 0; i < 9; i++)        // every limit's reset value, low byte only
         rd(8'h20 + 4 * i, LR[71 - 8 * i -: 8], 32'hff, 0);
      rd(8'h44, 0, 32'hffffffff, 2);
      wr(8'h00, 8'h12, 2);
      wr(8'h14, 8'h0a, 0);
      rd(8'h14, 8'h0a, 32'hffffffff, 0);
      $display("test registers done");
      open <= 1;
      wt(1000);
      `CHK(starts > 0, 1'b1)
      rd(8'h00, 8'h19, 32'hffffffff, 0);
      rd(8'h04, 8'h64, 32'hffffffff, 0);
      rd(8'h08, 8'h80, 32'hffffffff, 0);
      rd(8'h0c, 8'h16, 32'h7f, 0);
      `CHK(al_n, 1'b0)
      `CHK(ot_n, 1'b0)
      dly <= 9;
      wr(8'h20, 8'h10, 0);
      wt(1000);
      rd(8'h0c, 8'h56, 32'h7f, 0);
      $display("test conversion done");
      open <= 0;
      wr(8'h20, 8'h7f, 0);
      wr(8'h2c, 8'h7f, 0);
      wr(8'h3c, 8'h7f, 0);
      wt(1000);
      `CHK(ot_n, 1'b1)
      rd(8'h0c, 8'h54, 32'h7f, 0);
      rd(8'h0c, 8'h00, 32'h7f, 0);
      `CHK(al_n, 1'b0)
      rd(8'h18, 1, 1, 0);
      wt(4);
      `CHK(al_n, 1'b1)
      rd(8'h18, 0, 1, 0);
      $display("test flag clearing done");
      wr(8'h10, 8'h80, 0);
      wr(8'h20, 8'h10, 0);
      wt(1000);
      `CHK(al_n, 1'b1)
      rd(8'h0c, 8'h40, 32'h40, 0);
      wr(8'h10, 8'h40, 0);
      wt(400);
      i = starts;
      wt(600);
      `CHK(starts, i)
      rd(8'h10, 8'h40, 32'hffffffff, 0);
      rd(8'h0c, 0, 32'h80, 0);
      $display("test mask and standby done");
      link(6);
      sclk <= 0;
      wt(80);
      `CHK(rel, 1'b0)
      sclk <= 1;
      wr(8'h1c, 8'h01, 0);
      link(4);
      sclk <= 0;
      wt(40);
      `CHK(rel, 1'b0)
      wt(30);
      `CHK(rel, 1'b1)
      sclk <= 1;
      wt(6);
      `CHK(rel, 1'b0)
      $display("test bus timeout done");
      end_of_test;
   end
endmodule // tmon_core_test
